// ### lpdib_buffer.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: fifteen settable tab columns; only they may be forced into the column counter.
// R2: sixteenth setting is the end-of-line column; loading stops once it is written.
// R3: carriage return, stop, or end-of-line column end loading; print then feed follow.
// R4: a stop code prints the line then feeds to the top of the next page.
// R5: six-bit code picks one of 64 rows; one bit set per column.
// R6: after each write take the next character and step the column by one.
// R7: after loading, capture the drum position at its next update as start character.
// R8: print starts at any drum character; start character held for the whole line.
// R9: drum position selects a row; every set column fires its hammer.
// R10: the space code never fires a hammer.
// R11: each drum sync pulse advances the drum position by one, unless a revolution mark in the same cycle clears it to zero.
// R12: drum position back at start character ends printing, feeds (no lines in programmed mode), raises ready.
// R13: tab index starts at zero; each tab loads its column then steps.
// R14: page line counter counts fed lines; equal to page length means bottom.
// R15: at bottom feed one to four extra lines, then clear the line counter.
// R16: off-line self-test from two 6-bit counters; each line shifted by one code.
// R17: programmed mode: first character is a line count fed before printing.
// R18: automatic mode: single or double feed after each printed line.
// R19: verbatim mode: every code except space prints, lines end at end column, double feed.
// R20: no printing starts while the paper is still moving.
// R21: each new line starts at column zero with tab index zero.
// R22: image memory is cleared before each line is loaded.
module lpdib_buffer (
  input  wire logic                     mclk_in,
  input  wire logic                     rst_in,
  input  wire lpdib_pkg::lpdib_apb_req_t apb_in,
  output lpdib_pkg::lpdib_apb_rsp_t     apb_out,
  input  wire lpdib_pkg::lpdib_char_t   conv_in,
  output logic                          conv_ack_out,
  output logic                          ready_out,
  input  wire lpdib_pkg::lpdib_prn_t    prn_in,
  output logic [119:0]                  hammer_out,
  output logic                          feed_out
);
  import lpdib_pkg::*;

  typedef struct packed {
    lpdib_state_t           st;
    lpdib_ctrl_t            ctrl;
    logic [NPLUG-1:0][6:0]  tabs;
    logic [6:0]             col;
    logic [3:0]             tab_idx;
    logic [5:0]             clr_row;
    logic                   first;
    logic [5:0]             drum_pos;
    logic [5:0]             start_char;
    logic [5:0]             page_lines;
    logic [5:0]             feed_left;
    logic                   bottom;
    logic [2:0]             sep_left;
    logic                   to_top;
    logic [5:0]             test_line;
    logic [5:0]             test_char;
    logic [COLS-1:0]        hammer;
    logic                   feed;
    logic                   ready;
    logic                   ack;
    lpdib_apb_rsp_t         rsp;
  } lpdib_main_t;

  localparam logic [NPLUG*COL_W-1:0] TABS_RST = {EOL_RST, {NTAB{TAB_RST}}};
  localparam lpdib_main_t Q_RST = '{st: S_CLEAR, ctrl: CTRL_RST, tabs: TABS_RST, default: '0};

  lpdib_main_t q;
  lpdib_main_t next_q;

  logic [NPIN-1:0] pin_level;
  logic [NPIN-1:0] pin_rise;
  lpdib_prn_t      prn_lvl;
  lpdib_prn_t      prn_evt;
  logic [COLS-1:0] row_data;
  logic [COLS-1:0] fire_row;
  logic [5:0]      drum_next;
  logic            mem_clr;
  logic            mem_wr;
  logic [5:0]      code;
  logic            take;
  logic            ctl_ok;
  logic            count_char;
  logic            end_col;
  logic            feeding;
  lpdib_status_t   status;

  lpdib_pin_sync #(.N(NPIN)) u_pins (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pin_in    (prn_in),
    .level_out (pin_level),
    .rise_out  (pin_rise)
  );

  assign prn_lvl = lpdib_prn_t'(pin_level);
  assign prn_evt = lpdib_prn_t'(pin_rise);

  lpdib_image_mem u_mem (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .clr_in      (mem_clr),
    .clr_row_in  (q.clr_row),
    .wr_in       (mem_wr),
    .wr_row_in   (code),
    .wr_col_in   (q.col),
    .rd_row_in   (drum_next),
    .rd_data_out (row_data)
  );

  assign drum_next = q.drum_pos + 6'h01;
  // the space row is masked even if a stray bit were stored there
  assign fire_row  = (drum_next == CODE_SPACE) ? '0 : row_data; // R10 R9

  always_comb begin
    status            = '0;
    status.to_top     = q.to_top;
    status.bottom     = q.bottom;
    status.page_lines = q.page_lines;
    status.start_char = q.start_char;
    status.drum_pos   = q.drum_pos;
    status.col        = q.col;
    status.st         = q.st;
  end

  always_comb begin
    logic        hit;
    logic [31:0] rd_word;
    logic        is_tab;
    hit     = 1'b0;
    rd_word = '0;
    is_tab  = (apb_in.paddr[AW-1:TAB_SEL_LSB] == ADDR_TAB[AW-1:TAB_SEL_LSB])
              && (apb_in.paddr[TAB_IDX_LSB-1:0] == '0);
    next_q  = q;
    mem_clr = 1'b0;
    mem_wr  = 1'b0;
    take    = 1'b0;
    end_col = (q.col == q.tabs[EOL_IDX]) || (q.col == COL_LAST); // R2
    ctl_ok  = (q.ctrl.mode != MODE_VERB); // R19
    count_char = q.first && (q.ctrl.mode == MODE_PROG) && !q.ctrl.self_test; // R17
    code    = q.ctrl.self_test ? 6'(q.test_line + q.test_char) : conv_in.code; // R16
    feeding = (q.feed_left != '0) || q.to_top || q.bottom;

    // apb slave: read data caught in setup, answered in the first access cycle
    if (apb_in.paddr == ADDR_CTRL) begin
      hit     = 1'b1;
      rd_word = 32'(q.ctrl);
    end else if (apb_in.paddr == ADDR_STATUS) begin
      hit     = 1'b1;
      rd_word = 32'(status);
    end else if (is_tab) begin
      hit     = 1'b1;
      rd_word = 32'(q.tabs[apb_in.paddr[TAB_SEL_LSB-1:TAB_IDX_LSB]]);
    end
    next_q.rsp.pready = apb_in.psel & ~apb_in.penable;
    if (apb_in.psel && !apb_in.penable) begin
      next_q.rsp.prdata  = rd_word;
      next_q.rsp.pslverr = ~hit;
    end
    if (apb_in.psel && apb_in.penable && q.rsp.pready && apb_in.pwrite) begin
      if (apb_in.paddr == ADDR_CTRL) begin
        next_q.ctrl = lpdib_ctrl_t'(apb_in.pwdata[CTRL_W-1:0]);
      end else if (is_tab) begin
        next_q.tabs[apb_in.paddr[TAB_SEL_LSB-1:TAB_IDX_LSB]] = apb_in.pwdata[COL_W-1:0]; // R1
      end
    end

    // drum position follows the drum all the time
    if (prn_evt.drum_rev) begin
      next_q.drum_pos = '0;
    end else if (prn_evt.drum_sync) begin
      next_q.drum_pos = drum_next; // R11
    end

    next_q.ack    = 1'b0;
    next_q.hammer = '0;
    next_q.feed   = 1'b0;

    case (q.st)
      S_CLEAR: begin
        mem_clr          = 1'b1; // R22
        next_q.clr_row   = q.clr_row + 6'h01;
        next_q.col       = COL_FIRST; // R21
        next_q.tab_idx   = '0; // R13 R21
        next_q.test_char = '0;
        next_q.first     = 1'b1;
        if (q.clr_row == CHR_LAST) begin
          next_q.st = S_LOAD;
        end
      end
      S_LOAD: begin
        // ack lags one cycle, so a held valid is not taken twice
        take = q.ctrl.self_test || (conv_in.valid && !q.ack);
        if (take) begin
          next_q.ack   = ~q.ctrl.self_test; // R6
          next_q.first = 1'b0;
          if (count_char) begin
            next_q.feed_left = code; // R17
            next_q.st        = S_PREFEED;
          end else if (q.ctrl.self_test) begin
            mem_wr           = 1'b1;
            next_q.col       = q.col + 7'h01;
            next_q.test_char = q.test_char + 6'h01;
            if (end_col || (q.test_char == CHR_LAST)) begin
              next_q.st = S_WAITSYN;
            end
          end else if (ctl_ok && (code == CODE_CR)) begin
            next_q.st = S_WAITSYN; // R3
          end else if (ctl_ok && (code == CODE_STOP)) begin
            next_q.st     = S_WAITSYN; // R3
            next_q.to_top = 1'b1; // R4
          end else if (ctl_ok && (code == CODE_TAB)) begin
            if (q.tab_idx < TAB_LIMIT) begin
              next_q.col     = q.tabs[q.tab_idx]; // R1 R13
              next_q.tab_idx = q.tab_idx + 4'h1;
            end
          end else if (ctl_ok && (code == CODE_SPACE)) begin
            next_q.col = q.col + 7'h01; // R10
            if (end_col) begin
              next_q.st = S_WAITSYN;
            end
          end else if (ctl_ok && ((code == CODE_MSPACE) || (code == CODE_NOP1)
                                  || (code == CODE_NOP2) || (code == CODE_NOP3))) begin
            next_q.col = q.col;
          end else begin
            mem_wr     = 1'b1; // R5
            next_q.col = q.col + 7'h01; // R6
            if (end_col) begin
              next_q.st = S_WAITSYN; // R2 R3
            end
          end
        end
      end
      S_WAITSYN: begin
        // a line never starts on moving paper
        if (prn_evt.drum_sync && !prn_evt.drum_rev && !prn_lvl.paper_moving) begin // R20
          next_q.start_char = drum_next; // R7 R8
          next_q.hammer     = fire_row; // R9
          next_q.st         = S_PRINT;
        end
      end
      S_PRINT: begin
        if (prn_evt.drum_sync && !prn_evt.drum_rev) begin
          if (drum_next == q.start_char) begin
            next_q.st = S_FEED; // R12
            if (q.ctrl.self_test) begin
              next_q.feed_left = 6'h01;
              next_q.test_line = q.test_line + 6'h01; // R16
            end else if (q.ctrl.mode == MODE_VERB) begin
              next_q.feed_left = 6'h02; // R19
            end else if (q.ctrl.mode == MODE_AUTO) begin
              next_q.feed_left = q.ctrl.double_feed ? 6'h02 : 6'h01; // R18
            end else begin
              next_q.feed_left = '0; // R17
            end
          end else begin
            next_q.hammer = fire_row; // R9
          end
        end
      end
      S_PREFEED, S_FEED: begin
        next_q.feed = feeding;
        if (prn_evt.line_fed) begin
          if (q.bottom) begin
            next_q.sep_left = q.sep_left - 3'h1;
            if (q.sep_left == 3'h1) begin
              next_q.bottom     = 1'b0; // R15
              next_q.page_lines = '0;
              next_q.to_top     = 1'b0; // R4
            end
          end else begin
            next_q.page_lines = q.page_lines + 6'h01; // R14
            if ((q.page_lines + 6'h01) == q.ctrl.page_len) begin
              next_q.bottom   = 1'b1; // R14
              next_q.sep_left = {1'b0, q.ctrl.sep} + 3'h1; // R15
            end
          end
          if (q.feed_left != '0) begin
            next_q.feed_left = q.feed_left - 6'h01;
          end
        end
        if (!feeding) begin
          next_q.st = (q.st == S_PREFEED) ? S_LOAD : S_CLEAR;
        end
      end
      default: begin
        next_q.st = S_CLEAR;
      end
    endcase
    next_q.ready = (next_q.st == S_LOAD); // R12
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= Q_RST;
    end else begin
      q <= next_q;
    end
  end

  assign apb_out      = q.rsp;
  assign conv_ack_out = q.ack;
  assign ready_out    = q.ready;
  assign hammer_out   = q.hammer;
  assign feed_out     = q.feed;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  chk_start_held: assert property ((q.st == S_PRINT) && ($past(q.st) == S_PRINT) // R8
    |-> q.start_char == $past(q.start_char)) else $error("start char changed mid line");
  chk_drum_step: assert property (prn_evt.drum_sync && !prn_evt.drum_rev // R11
    |=> q.drum_pos == 6'($past(q.drum_pos) + 6'h01)) else $error("drum position not stepped");
  chk_print_done: assert property ((q.st == S_PRINT) && prn_evt.drum_sync // R12
    && !prn_evt.drum_rev && (drum_next == q.start_char)
    |=> (q.st == S_FEED) ##[1:2] (q.st != S_PRINT)) else $error("line end missed");
  chk_space_silent: assert property ((q.st == S_PRINT) && prn_evt.drum_sync // R10
    && (drum_next == CODE_SPACE) |=> hammer_out == '0) else $error("space fired a hammer");
  chk_tab_load: assert property ((q.st == S_LOAD) && take && !count_char && ctl_ok // R13
    && !q.ctrl.self_test && (code == CODE_TAB) && (q.tab_idx < TAB_LIMIT)
    |=> (q.col == $past(q.tabs[q.tab_idx])) && (q.tab_idx == 4'($past(q.tab_idx) + 4'h1)))
    else $error("tab did not load column");
  chk_line_start: assert property ((q.st == S_CLEAR) |=> (q.col == COL_FIRST) // R21
    && (q.tab_idx == '0)) else $error("line not started at column zero");
  chk_clear_rows: assert property ((q.st == S_LOAD) && ($past(q.st) == S_CLEAR) // R22
    |-> $past(q.clr_row) == CHR_LAST) else $error("memory not fully cleared");
  chk_eol_stop: assert property ((q.st == S_LOAD) && mem_wr && end_col // R2
    |=> q.st == S_WAITSYN) else $error("load ran past end column");
  chk_paper_hold: assert property ((q.st == S_WAITSYN) && prn_lvl.paper_moving // R20
    |=> q.st == S_WAITSYN) else $error("print began on moving paper");
  chk_page_clear: assert property (q.bottom && prn_evt.line_fed && (q.sep_left == 3'h1) // R15
    && (q.st == S_FEED) |=> (q.page_lines == '0) && !q.bottom) else $error("page not closed");
  chk_ready_load: assert property ((q.st == S_LOAD) |-> ready_out) // R12
    else $error("ready low while loading");

  cov_line_print: cover property ((q.st == S_PRINT) ##1 (q.st == S_FEED));
  cov_page_top:   cover property (q.to_top && (q.st == S_FEED));
  cov_bottom:     cover property (q.bottom && prn_evt.line_fed);
  cov_self_test:  cover property (q.ctrl.self_test && (q.st == S_PRINT));
endmodule // lpdib_buffer

// ### lpdib_pkg.sv
package lpdib_pkg;

  localparam int COLS   = 120;
  localparam int ROWS   = 64;
  localparam int COL_W  = 7;
  localparam int CHR_W  = 6;
  localparam int NTAB   = 15;
  localparam int NPLUG  = 16;
  localparam int NPIN   = 4;

  // character codes with a control meaning
  localparam logic [5:0] CODE_MSPACE = 6'h00;
  localparam logic [5:0] CODE_NOP1   = 6'h01;
  localparam logic [5:0] CODE_NOP2   = 6'h02;
  localparam logic [5:0] CODE_TAB    = 6'h03;
  localparam logic [5:0] CODE_CR     = 6'h04;
  localparam logic [5:0] CODE_SPACE  = 6'h05;
  localparam logic [5:0] CODE_STOP   = 6'h2f;
  localparam logic [5:0] CODE_NOP3   = 6'h3f;
  localparam logic [5:0] CHR_LAST    = 6'h3f;

  localparam logic [6:0] COL_FIRST   = 7'h00;
  localparam logic [6:0] COL_LAST    = 7'h77;
  localparam logic [6:0] TAB_RST     = 7'h00;
  localparam logic [6:0] EOL_RST     = 7'h77;
  localparam logic [3:0] EOL_IDX     = 4'hf;
  localparam logic [3:0] TAB_LIMIT   = 4'hf;

  // apb map
  localparam int         AW            = 12;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_TAB     = 12'h040;
  localparam int         TAB_SEL_LSB   = 6;
  localparam int         TAB_IDX_LSB   = 2;

  typedef enum logic [1:0] {
    MODE_PROG = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_VERB = 2'b10
  } lpdib_mode_t;

  typedef enum logic [2:0] {
    S_CLEAR   = 3'b000,
    S_LOAD    = 3'b001,
    S_PREFEED = 3'b010,
    S_WAITSYN = 3'b011,
    S_PRINT   = 3'b100,
    S_FEED    = 3'b101
  } lpdib_state_t;

  typedef struct packed {
    logic [1:0]  sep;
    logic [5:0]  page_len;
    logic        self_test;
    logic        double_feed;
    lpdib_mode_t mode;
  } lpdib_ctrl_t;

  localparam int CTRL_W = $bits(lpdib_ctrl_t);
  localparam lpdib_ctrl_t CTRL_RST = '{sep: 2'h0, page_len: 6'h3c, self_test: 1'b0,
                                       double_feed: 1'b0, mode: MODE_AUTO};

  typedef struct packed {
    logic [1:0]   pad;
    logic         to_top;
    logic         bottom;
    logic [5:0]   page_lines;
    logic [5:0]   start_char;
    logic [5:0]   drum_pos;
    logic [6:0]   col;
    lpdib_state_t st;
  } lpdib_status_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lpdib_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lpdib_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] code;
  } lpdib_char_t;

  // printer pins, bit order also used by the pin filter
  typedef struct packed {
    logic paper_moving;
    logic line_fed;
    logic drum_rev;
    logic drum_sync;
  } lpdib_prn_t;

endpackage

// ### lpdib_pin_sync.sv
`timescale 1ns/1ps
module lpdib_pin_sync #(
  parameter int N = 4
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] level_out,
  output logic      [N-1:0] rise_out
);
  import lpdib_pkg::*;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] stable;
    logic [N-1:0] rise;
  } lpdib_sync_t;

  lpdib_sync_t  q;
  lpdib_sync_t  next_q;
  logic [N-1:0] next_stable;

  // a change is believed only once stages two and three agree
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign next_stable[i] = (q.s2[i] == q.s3[i]) ? q.s2[i] : q.stable[i];
  end

  always_comb begin
    next_q        = q;
    next_q.s1     = pin_in;
    next_q.s2     = q.s1;
    next_q.s3     = q.s2;
    next_q.stable = next_stable;
    next_q.rise   = next_stable & ~q.stable;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level_out = q.stable;
  assign rise_out  = q.rise;
endmodule // lpdib_pin_sync

// ### lpdib_image_mem.sv
`timescale 1ns/1ps
module lpdib_image_mem (
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wire logic         clr_in,
  input  wire logic [5:0]   clr_row_in,
  input  wire logic         wr_in,
  input  wire logic [5:0]   wr_row_in,
  input  wire logic [6:0]   wr_col_in,
  input  wire logic [5:0]   rd_row_in,
  output logic      [119:0] rd_data_out
);
  import lpdib_pkg::*;

  typedef struct packed {
    logic [ROWS-1:0][COLS-1:0] img;
  } lpdib_mem_t;

  lpdib_mem_t q;
  lpdib_mem_t next_q;

  always_comb begin
    next_q = q;
    if (clr_in) begin
      next_q.img[clr_row_in] = '0;
    end
    // one bit per character: row from the code, column from the counter
    if (wr_in && (wr_col_in <= COL_LAST)) begin
      next_q.img[wr_row_in][wr_col_in] = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // whole row read at once, one bit per hammer
  assign rd_data_out = q.img[rd_row_in];
endmodule // lpdib_image_mem

// ### lpdib_printer_model.sv
`timescale 1ns/1ps
module lpdib_printer_model (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic             feed_in,
  output lpdib_pkg::lpdib_prn_t prn_out,
  output logic [5:0]            pos_out
);
  import lpdib_pkg::*;
  typedef struct packed {
    lpdib_prn_t prn;
    logic [5:0] pos;
    logic [4:0] sc;
    logic [5:0] fc;
    logic [4:0] mc;
  } lpdib_mdl_t;
  lpdib_mdl_t s;
  lpdib_mdl_t next_s;
  always_comb begin
    next_s = s;
    next_s.sc = (s.sc == 5'h13) ? 5'h00 : s.sc + 5'h01;
    next_s.prn.drum_sync = (s.sc < 5'h04);
    if (s.sc == 5'h00) begin
      next_s.pos = s.pos + 6'h01;
    end
    // position kept by counting, so the revolution mark stays quiet
    next_s.prn.drum_rev = 1'b0;
    next_s.fc = feed_in ? ((s.fc == 6'h27) ? 6'h00 : s.fc + 6'h01) : 6'h00;
    next_s.prn.line_fed = feed_in && (s.fc >= 6'h1e) && (s.fc < 6'h22);
    next_s.mc = feed_in ? 5'h14 : ((s.mc != 5'h00) ? s.mc - 5'h01 : 5'h00);
    next_s.prn.paper_moving = feed_in || (s.mc != 5'h00);
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign prn_out = s.prn;
  assign pos_out = s.pos;
endmodule // lpdib_printer_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
  import lpdib_pkg::*;
  typedef struct packed { logic rd; logic err; logic [31:0] d; } lpdib_apbx_t;
  typedef struct packed { int h; int f; } lpdib_line_t;
  logic           mclk_in = 1'b0;
  logic           rst_in = 1'b1;
  lpdib_apb_req_t apb_in = '0;
  lpdib_apb_rsp_t apb_out;
  lpdib_char_t    conv_in = '0;
  logic           conv_ack_out;
  logic           ready_out;
  logic           feed_out;
  logic [119:0]   hammer_out;
  lpdib_prn_t     prn;
  logic [5:0]     pos;
  logic           lf_q = 1'b0;
  logic           fd_q = 1'b0;
  int             errors = 0;
  int             checks = 0;
  int             pl = 0;
  int             carry = 0;
  int             hc = 0;
  int             fc = 0;
  lpdib_apbx_t    aq[$];
  lpdib_line_t    lq[$];
  logic [119:0]   img [64];
  logic [6:0]     tabs [16];
  logic [5:0]     v[$];
  always #25 mclk_in = ~mclk_in;
  lpdib_buffer dut (.mclk_in(mclk_in), .rst_in(rst_in), .apb_in(apb_in), .apb_out(apb_out),
    .conv_in(conv_in), .conv_ack_out(conv_ack_out), .ready_out(ready_out), .prn_in(prn),
    .hammer_out(hammer_out), .feed_out(feed_out));
  lpdib_printer_model printer (.mclk_in(mclk_in), .rst_in(rst_in), .feed_in(feed_out),
    .prn_out(prn), .pos_out(pos));
  task automatic tally_and_finish();
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic fail(string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp_apb(lpdib_apbx_t e);
    checks++;
    if (apb_out.pslverr !== e.err || (e.rd && apb_out.prdata !== e.d)) fail("apb response");
  endtask
  task automatic cmp_row(logic [119:0] e);
    checks++;
    if (hammer_out !== e) fail("hammer row");
  endtask
  task automatic cmp_line(lpdib_line_t e);
    checks++;
    if (hc != e.h || fc != e.f) fail("line hammer or feed count");
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic err);
    @(posedge mclk_in);
    aq.push_back('{rd: !wr, err: err, d: d});
    apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk_in);
    apb_in.penable <= 1'b1;
    do @(posedge mclk_in); while (apb_out.pready !== 1'b1);
    apb_in <= '0;
  endtask
  task automatic send(logic [5:0] code);
    @(posedge mclk_in);
    conv_in <= '{valid: 1'b1, code: code};
    do @(posedge mclk_in); while (conv_ack_out !== 1'b1);
    conv_in.valid <= 1'b0;
  endtask
  task automatic setc(logic [1:0] sep, logic [5:0] plen, logic dbl, lpdib_mode_t m);
    wait (ready_out === 1'b1);
    apb(1'b1, ADDR_CTRL, {20'h0, sep, plen, 1'b0, dbl, m}, 1'b0);
  endtask
  task automatic line(lpdib_mode_t m, logic [5:0] c[$], int nf);
    int col, ti, h, k;
    logic done, ctl;
    col = 0;
    ti = 0;
    h = 0;
    done = 1'b0;
    ctl = (m != MODE_VERB);
    wait (ready_out === 1'b1);
    for (k = 0; k < 64; k++) img[k] = '0;
    if (m == MODE_PROG) lq.push_back('{h: 0, f: c[0]});
    if (m == MODE_PROG) pl += c[0];
    for (k = 0; k < c.size() && !done; k++) begin
      send(c[k]);
      if (m == MODE_PROG && k == 0) continue;
      if (ctl && (c[k] == CODE_CR || c[k] == CODE_STOP)) done = 1'b1;
      else if (ctl && c[k] == CODE_TAB) begin
        col = tabs[ti];
        ti++;
      end else if (ctl && c[k] == CODE_SPACE) begin
        done = (col == tabs[15] || col == COL_LAST);
        col++;
      end else if (ctl && c[k] inside {CODE_MSPACE, CODE_NOP1, CODE_NOP2, CODE_NOP3}) begin
      end else begin
        img[c[k]][col] = 1'b1;
        h++;
        done = (col == tabs[15] || col == COL_LAST);
        col++;
      end
    end
    if (m == MODE_PROG) carry = h;
    else lq.push_back('{h: h + carry, f: nf});
    if (m != MODE_PROG) carry = 0;
    pl += nf;
    wait (ready_out !== 1'b1);
  endtask
  always @(posedge mclk_in) begin
    if (apb_in.psel && apb_in.penable && apb_out.pready === 1'b1 && aq.size() > 0)
      cmp_apb(aq.pop_front());
    if (|hammer_out) begin
      cmp_row(img[pos]);
      hc += $countones(hammer_out);
    end
    if (prn.line_fed === 1'b1 && lf_q !== 1'b1) fc++;
    if (fd_q === 1'b1 && feed_out === 1'b0 && lq.size() > 0) begin
      cmp_line(lq.pop_front());
      hc = 0;
      fc = 0;
    end
    lf_q <= prn.line_fed;
    fd_q <= feed_out;
  end
  initial begin
    repeat (40000) @(posedge mclk_in);
    errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h8811));
    for (int k = 0; k < 16; k++) tabs[k] = (k == 15) ? EOL_RST : TAB_RST;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    wait (ready_out === 1'b1);
    apb(1'b0, ADDR_CTRL, 32'h3c1, 1'b0);
    apb(1'b0, ADDR_TAB + 12'h03c, 32'h77, 1'b0);
    apb(1'b0, ADDR_TAB, 32'h0, 1'b0);
    apb(1'b1, 12'h008, 32'h5, 1'b1);
    apb(1'b0, 12'h008, 32'h0, 1'b1);
    tabs[0] = 7'h0a;
    tabs[1] = 7'h1e;
    tabs[15] = 7'h14;
    apb(1'b1, ADDR_TAB, 32'h0a, 1'b0);
    apb(1'b1, ADDR_TAB + 12'h004, 32'h1e, 1'b0);
    apb(1'b1, ADDR_TAB + 12'h03c, 32'h14, 1'b0);
    apb(1'b0, ADDR_TAB + 12'h004, 32'h1e, 1'b0);
    setc(2'h0, 6'h3c, 1'b0, MODE_AUTO);
    line(MODE_AUTO, '{6'h06, 6'h05, 6'h07, 6'h01, 6'h03, 6'h08, 6'h03, 6'h09, 6'h04}, 1);
    setc(2'h0, 6'h3c, 1'b1, MODE_AUTO);
    line(MODE_AUTO, '{6'h03, 6'h10, 6'h04}, 2);
    setc(2'h0, 6'h3c, 1'b0, MODE_PROG);
    line(MODE_PROG, '{6'h02, 6'h21, 6'h22, 6'h04}, 0);
    for (int k = 0; k < 21; k++)
      v.push_back(k == 3 ? CODE_TAB : k == 7 ? CODE_CR : k == 9 ? CODE_STOP : 6'(6 + $urandom % 40));
    setc(2'h0, 6'h3c, 1'b0, MODE_VERB);
    line(MODE_VERB, v, 2);
    setc(2'h1, 6'h09, 1'b0, MODE_AUTO);
    line(MODE_AUTO, '{6'h30, 6'h05, 6'h31, CODE_STOP}, 9 - pl + 2);
    pl = 0;
    wait (ready_out === 1'b1);
    // self-test line: code k at column k up to the end column, space row silent
    for (int k = 0; k < 64; k++) img[k] = (k < 21 && k != 5) ? (120'(1) << k) : '0;
    lq.push_back('{h: 20, f: 1});
    apb(1'b1, ADDR_CTRL, 32'h3c9, 1'b0);
    wait (ready_out !== 1'b1);
    wait (ready_out === 1'b1);
    tally_and_finish();
  end
endmodule // tb
